// >>> cwg_pkg.sv
/*
 Constants for the channel waveform generator: register offsets, field
 positions, reset values and widths. Assumes a plain byte-wide register port.
*/
package cwg_pkg;
   localparam int NUM_CH = 6;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [7:0] OFF_CNT_LO = 8'h00;
   localparam logic [7:0] OFF_CNT_HI = 8'h01;
   localparam logic [7:0] OFF_CNT_MODE = 8'h02;
   localparam logic [7:0] OFF_PULSE_CFG = 8'h03;
   localparam logic [7:0] OFF_INVERT = 8'h04;
   localparam logic [7:0] OFF_CENTER = 8'h05;
   localparam logic [7:0] OFF_EVT_FLAGS = 8'h06;
   localparam logic [7:0] OFF_CH_BASE = 8'h10;
   localparam logic [7:0] OFF_CH_STRIDE = 8'h04;
   localparam logic [1:0] CH_MODE = 2'h0;
   localparam logic [1:0] CH_LOW = 2'h1;
   localparam logic [1:0] CH_HIGH = 2'h2;
   // Channel mode register fields
   localparam int MODE_WIDE_BIT = 7;
   localparam int MODE_ENABLE_BIT = 6;
   localparam int MODE_MATCH_BIT = 3;
   localparam int MODE_TOGGLE_BIT = 2;
   localparam int MODE_PULSE_BIT = 1;
   // Counter mode register: run bit and clock select field
   localparam int CNT_RUN_BIT = 0;
   localparam int CNT_SEL_LSB = 1;
   localparam int CNT_SEL_W = 3;
   // Pulse group config: cycle length field
   localparam int CYC_LSB = 0;
   localparam int CYC_W = 2;
   localparam logic [1:0] CYC_8BIT = 2'h0;
   // Reset values, unmapped read value and prescaler width
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   localparam int PRESC_W = 6;
endpackage

// >>> cwg_chan.sv
/*
 One waveform channel: frequency output, edge and center aligned PWM.
 Assumes a shared counter with a one-cycle advance pulse and a single clock.
*/
module cwg_chan (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_tick,
   input wire logic [16:0] i_cnt,
   input wire logic [7:0] i_mode,
   input wire logic [1:0] i_cyc,
   input wire logic i_center,
   input wire logic i_invert,
   input wire logic i_wr_low,
   input wire logic i_wr_high,
   input wire logic [7:0] i_wdata,
   output logic [15:0] o_cmp,
   output logic o_enable,
   output logic o_event,
   output logic o_pin
);
   logic [7:0] cmp_low_r;
   logic [7:0] cmp_high_r;
   logic enable_r;
   logic raw_r;
   logic pin_r;
   logic wide, pulse, toggle, freq_mode, pwm_mode;
   logic [4:0] res;
   logic [15:0] nmask, cmp_m, cnt_m, cnt_m1;
   logic sel_bit, ovf_edge, match_edge, up_edge, dn_edge;
   logic [15:0] cmp_full;

   assign cmp_full = {cmp_high_r, cmp_low_r};
   assign wide = i_mode[cwg_pkg::MODE_WIDE_BIT];
   assign pulse = i_mode[cwg_pkg::MODE_PULSE_BIT];
   assign toggle = i_mode[cwg_pkg::MODE_TOGGLE_BIT];
   assign freq_mode = enable_r & toggle & pulse;
   assign pwm_mode = pulse & ~toggle;
   // Resolution: wide channels 16 bits, else group 8..11 bits
   assign res = wide ? 5'd16 : (5'd8 + {3'd0, i_cyc});
   assign nmask = wide ? 16'hFFFF : 16'((17'h1 << res) - 17'h1);
   assign cmp_m = cmp_full & nmask;
   assign cnt_m = i_cnt[15:0] & nmask;
   assign cnt_m1 = 16'(i_cnt[15:0] - 16'h1) & nmask;
   assign sel_bit = i_cnt[res];
   assign match_edge = enable_r & (cmp_m == cnt_m);
   assign ovf_edge = (cnt_m == 16'h0000);
   assign dn_edge = enable_r & sel_bit
                    & ((~cmp_full & nmask) == cnt_m);
   // All-ones compare would match at the wrap to zero; gated for 0% duty
   assign up_edge = enable_r & ~sel_bit & (cmp_m == cnt_m1)
                    & (cmp_m != nmask);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         enable_r <= 1'b0;
      end else if (i_wr_high) begin
         enable_r <= 1'b1;
      end else if (i_wr_low) begin
         enable_r <= 1'b0;
      end else begin
         enable_r <= i_mode[cwg_pkg::MODE_ENABLE_BIT];
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cmp_high_r <= cwg_pkg::RST_BYTE;
      end else if (i_wr_high) begin
         cmp_high_r <= i_wdata;
      end
   end

   // Software write wins over a same-cycle hardware update
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cmp_low_r <= cwg_pkg::RST_BYTE;
      end else if (i_wr_low) begin
         cmp_low_r <= i_wdata;
      end else if (i_tick && freq_mode && cmp_low_r == i_cnt[7:0]) begin
         cmp_low_r <= 8'(cmp_low_r + cmp_high_r);
      end else if (i_tick && pwm_mode && !wide && i_cyc == cwg_pkg::CYC_8BIT
                   && (i_center ? up_edge : ovf_edge)) begin
         cmp_low_r <= cmp_high_r;
      end
   end

   // Output state before inversion, updated only on counter advance
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         raw_r <= 1'b0;
      end else if (i_tick) begin
         if (freq_mode) begin
            if (cmp_low_r == i_cnt[7:0]) begin
               raw_r <= ~raw_r;
            end
         end else if (pwm_mode && !enable_r) begin
            raw_r <= 1'b0;
         end else if (pwm_mode && !i_center) begin
            if (match_edge) begin
               raw_r <= 1'b1;
            end else if (ovf_edge) begin
               raw_r <= 1'b0;
            end
         end else if (pwm_mode) begin
            // Both-ones compare never hits an up edge: 0% duty
            if (cmp_m == 16'h0000) begin
               raw_r <= 1'b1;
            end else if (up_edge) begin
               raw_r <= 1'b1;
            end else if (dn_edge) begin
               raw_r <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pin_r <= 1'b0;
      end else begin
         pin_r <= raw_r ^ i_invert;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_event <= 1'b0;
      end else begin
         o_event <= i_tick & freq_mode & i_mode[cwg_pkg::MODE_MATCH_BIT]
                    & (i_cnt[15:0] == cmp_full);
      end
   end

   assign o_pin = pin_r;
   assign o_cmp = cmp_full;
   assign o_enable = enable_r;

   edge_polarity_a: assert property (@(posedge i_clk) disable iff (i_reset)
      ##1 (pin_r == ($past(raw_r) ^ $past(i_invert))))
      else $error("pin does not follow inverted raw state");
   hold_no_tick_a: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_tick |=> $stable(raw_r))
      else $error("output moved without counter advance");
   freq_toggle_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_tick && freq_mode && cmp_low_r == i_cnt[7:0] && !i_wr_low)
      |=> raw_r != $past(raw_r) && cmp_low_r == 8'($past(cmp_low_r)
      + $past(cmp_high_r)))
      else $error("frequency match did not toggle and advance");
   edge_match_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_tick && pwm_mode && !i_center && match_edge) |=> raw_r)
      else $error("match edge did not set output");
   edge_ovf_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_tick && pwm_mode && !i_center && !match_edge && ovf_edge)
      |=> !raw_r)
      else $error("overflow edge did not clear output");
   zero_duty_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_tick && pwm_mode && !enable_r) |=> !raw_r)
      else $error("disabled pwm channel drove high");
   center_down_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_tick && pwm_mode && i_center && dn_edge && cmp_m != 16'h0000
      && !up_edge) |=> !raw_r)
      else $error("down edge did not clear output");
   low_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_wr_low && !i_wr_high) |=> !enable_r ##1 1'b1)
      else $error("low byte write left compare enabled");
   reload_8bit_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_tick && pwm_mode && !wide && i_cyc == cwg_pkg::CYC_8BIT
      && !i_center && ovf_edge && !i_wr_low)
      |=> cmp_low_r == $past(cmp_high_r))
      else $error("8-bit reload missed on overflow");
   event_flag_a: assert property (@(posedge i_clk) disable iff (i_reset)
      o_event |-> $past(i_cnt[15:0]) == $past(cmp_full))
      else $error("event without full compare match");
   freq_c: cover property (@(posedge i_clk) freq_mode && raw_r ##1 !raw_r);
   edge_c: cover property (@(posedge i_clk) pwm_mode && !i_center
      && match_edge && i_tick);
   center_c: cover property (@(posedge i_clk) pwm_mode && i_center
      && up_edge && i_tick);
endmodule

// >>> cwg_top.sv
/*
 Channel waveform generator top: shared counter, registers, six channels.
 Assumes a synchronous byte register port with read data one cycle later.
*/
// The implementer's own choices: the placing of the registers and the strobed register port.
module cwg_top (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [cwg_pkg::ADDR_W-1:0] i_addr,
   input wire logic [cwg_pkg::DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_ext_clk,
   output logic [cwg_pkg::DATA_W-1:0] o_rdata,
   output logic [cwg_pkg::NUM_CH-1:0] o_chan_out_pin,
   output logic [cwg_pkg::NUM_CH-1:0] o_chan_event_flag
);
   localparam int N = cwg_pkg::NUM_CH;

   logic [16:0] shared_counter_r;
   logic [7:0] counter_mode_reg_r;
   logic [7:0] pulse_group_config_r;
   logic [N-1:0] output_invert_select_r;
   logic [N-1:0] center_align_select_r;
   logic [7:0] chan_mode_reg_r [N];
   logic [N-1:0] event_flag_r;
   logic [cwg_pkg::PRESC_W-1:0] presc_r;
   logic ext_d_r;
   logic tick_r;
   logic tick_nxt;
   logic [7:0] rdata_nxt;
   logic [15:0] ch_cmp [N];
   logic [N-1:0] ch_enable, ch_event, ch_pin;
   logic [N-1:0] wr_low, wr_high, wr_mode;
   logic [2:0] clk_sel;
   logic [1:0] cyc;
   logic ch_sel;
   logic [7:0] ch_off;
   logic [2:0] ch_idx;
   logic [1:0] ch_reg;

   assign clk_sel = counter_mode_reg_r[cwg_pkg::CNT_SEL_LSB +:
                                       cwg_pkg::CNT_SEL_W];
   assign cyc = pulse_group_config_r[cwg_pkg::CYC_LSB +: cwg_pkg::CYC_W];
   assign ch_off = i_addr - cwg_pkg::OFF_CH_BASE;
   assign ch_idx = ch_off[4:2];
   assign ch_reg = ch_off[1:0];
   assign ch_sel = (i_addr >= cwg_pkg::OFF_CH_BASE)
                   && (ch_off < 8'(N * 4)) && (ch_reg != 2'h3);

   // Counter clock select: system clock, divided by 4/12/48, or ext edge
   always_comb begin
      unique case (clk_sel)
         3'h0: tick_nxt = 1'b1;
         3'h1: tick_nxt = (presc_r[1:0] == 2'h3);
         3'h2: tick_nxt = (presc_r == 6'h0B) || (presc_r == 6'h17)
                          || (presc_r == 6'h23) || (presc_r == 6'h2F);
         3'h3: tick_nxt = (presc_r == 6'h2F);
         3'h4: tick_nxt = i_ext_clk & ~ext_d_r;
         default: tick_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         presc_r <= '0;
         ext_d_r <= 1'b0;
      end else begin
         presc_r <= (presc_r == 6'h2F) ? 6'h00 : presc_r + 6'h01;
         ext_d_r <= i_ext_clk;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= tick_nxt & counter_mode_reg_r[cwg_pkg::CNT_RUN_BIT];
      end
   end

   // 17 bits: top bit selects center edges in 16-bit mode
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         shared_counter_r <= {1'b0, cwg_pkg::RST_CNT};
      end else if (i_wr && i_addr == cwg_pkg::OFF_CNT_LO) begin
         shared_counter_r[7:0] <= i_wdata;
      end else if (i_wr && i_addr == cwg_pkg::OFF_CNT_HI) begin
         shared_counter_r[15:8] <= i_wdata;
      end else if (tick_r) begin
         shared_counter_r <= shared_counter_r + 17'h1;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         counter_mode_reg_r <= cwg_pkg::RST_BYTE;
         pulse_group_config_r <= cwg_pkg::RST_BYTE;
         output_invert_select_r <= '0;
         center_align_select_r <= '0;
      end else if (i_wr) begin
         if (i_addr == cwg_pkg::OFF_CNT_MODE) begin
            counter_mode_reg_r <= i_wdata;
         end
         if (i_addr == cwg_pkg::OFF_PULSE_CFG) begin
            pulse_group_config_r <= i_wdata;
         end
         if (i_addr == cwg_pkg::OFF_INVERT) begin
            output_invert_select_r <= i_wdata[N-1:0];
         end
         if (i_addr == cwg_pkg::OFF_CENTER) begin
            center_align_select_r <= i_wdata[N-1:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         assign wr_mode[g] = i_wr && ch_sel && ch_idx == 3'(g)
                             && ch_reg == cwg_pkg::CH_MODE;
         assign wr_low[g] = i_wr && ch_sel && ch_idx == 3'(g)
                            && ch_reg == cwg_pkg::CH_LOW;
         assign wr_high[g] = i_wr && ch_sel && ch_idx == 3'(g)
                             && ch_reg == cwg_pkg::CH_HIGH;

         // Enable bit tracked in the channel so byte writes can move it
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               chan_mode_reg_r[g] <= cwg_pkg::RST_BYTE;
            end else if (wr_mode[g]) begin
               chan_mode_reg_r[g] <= i_wdata;
            end else if (wr_low[g] || wr_high[g]) begin
               chan_mode_reg_r[g][cwg_pkg::MODE_ENABLE_BIT]
                  <= wr_high[g];
            end
         end

         // Sticky: hardware set beats software clear
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               event_flag_r[g] <= 1'b0;
            end else if (ch_event[g]) begin
               event_flag_r[g] <= 1'b1;
            end else if (i_wr && i_addr == cwg_pkg::OFF_EVT_FLAGS
                         && !i_wdata[g]) begin
               event_flag_r[g] <= 1'b0;
            end
         end

         cwg_chan u_chan (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_tick(tick_r),
            .i_cnt(shared_counter_r),
            .i_mode(chan_mode_reg_r[g]),
            .i_cyc(cyc),
            .i_center(center_align_select_r[g]),
            .i_invert(output_invert_select_r[g]),
            .i_wr_low(wr_low[g]),
            .i_wr_high(wr_high[g]),
            .i_wdata(i_wdata),
            .o_cmp(ch_cmp[g]),
            .o_enable(ch_enable[g]),
            .o_event(ch_event[g]),
            .o_pin(ch_pin[g])
         );
      end
   endgenerate

   always_comb begin
      rdata_nxt = cwg_pkg::RD_UNMAPPED;
      if (ch_sel) begin
         unique case (ch_reg)
            cwg_pkg::CH_MODE: rdata_nxt = chan_mode_reg_r[ch_idx];
            cwg_pkg::CH_LOW: rdata_nxt = ch_cmp[ch_idx][7:0];
            cwg_pkg::CH_HIGH: rdata_nxt = ch_cmp[ch_idx][15:8];
            default: rdata_nxt = cwg_pkg::RD_UNMAPPED;
         endcase
      end else begin
         unique case (i_addr)
            cwg_pkg::OFF_CNT_LO: rdata_nxt = shared_counter_r[7:0];
            cwg_pkg::OFF_CNT_HI: rdata_nxt = shared_counter_r[15:8];
            cwg_pkg::OFF_CNT_MODE: rdata_nxt = counter_mode_reg_r;
            cwg_pkg::OFF_PULSE_CFG: rdata_nxt = pulse_group_config_r;
            cwg_pkg::OFF_INVERT: rdata_nxt = {2'h0, output_invert_select_r};
            cwg_pkg::OFF_CENTER: rdata_nxt = {2'h0, center_align_select_r};
            cwg_pkg::OFF_EVT_FLAGS: rdata_nxt = {2'h0, event_flag_r};
            default: rdata_nxt = cwg_pkg::RD_UNMAPPED;
         endcase
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_rdata <= cwg_pkg::RD_UNMAPPED;
      end else begin
         o_rdata <= i_rd ? rdata_nxt : cwg_pkg::RD_UNMAPPED;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_chan_out_pin <= '0;
         o_chan_event_flag <= '0;
      end else begin
         o_chan_out_pin <= ch_pin;
         o_chan_event_flag <= event_flag_r;
      end
   end

   counter_step_a: assert property (@(posedge i_clk) disable iff (i_reset)
      (tick_r && !i_wr) |=> shared_counter_r
      == 17'($past(shared_counter_r) + 17'h1))
      else $error("counter did not advance on tick");
   flag_set_wins_a: assert property (@(posedge i_clk) disable iff (i_reset)
      ch_event[0] |=> event_flag_r[0])
      else $error("event flag lost on set");
   high_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
      wr_high[0] |=> ch_enable[0])
      else $error("high byte write did not enable compare");
   rd_c: cover property (@(posedge i_clk) i_rd ##1 o_rdata != 8'h00);
endmodule

// >>> cwg_load.sv
/*
 Load model at a channel output pin: counts high cycles and transitions.
 Assumes the bench pulses the clear input before each measuring window.
*/
module cwg_load (
   input wire logic i_clk,
   input wire logic i_pin,
   input wire logic i_clear,
   output logic [15:0] o_high,
   output logic [15:0] o_edges
);
   logic last_r;

   // A plain load: it samples the pin and never drives anything back
   always_ff @(posedge i_clk) begin
      last_r <= i_pin;
      if (i_clear) begin
         o_high <= 16'h0000;
         o_edges <= 16'h0000;
      end else begin
         o_high <= o_high + {15'h0000, i_pin};
         o_edges <= o_edges + {15'h0000, i_pin ^ last_r};
      end
   end
endmodule

// >>> testbench.sv
/*
 Self-checking bench for the channel waveform generator, channel 0.
 Assumes the register port of the top module and a load model on the pin.
*/
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk = 1'b0;
   logic i_reset = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_ext_clk = 1'b0;
   logic [7:0] o_rdata;
   logic [5:0] o_chan_out_pin;
   logic [5:0] o_chan_event_flag;
   logic clr = 1'b0;
   logic [15:0] load_high;
   logic [15:0] load_edges;
   logic [15:0] hi;
   logic [15:0] ed;
   int num_errors = 0;
   int comparisons = 0;

   cwg_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_clk(i_ext_clk),
      .o_rdata(o_rdata), .o_chan_out_pin(o_chan_out_pin),
      .o_chan_event_flag(o_chan_event_flag));
   cwg_load load (.i_clk(i_clk), .i_pin(o_chan_out_pin[0]),
      .i_clear(clr), .o_high(load_high), .o_edges(load_edges));

   always #12.5 i_clk = ~i_clk;
   // Slow external counter clock, period of eight system cycles
   always #100 i_ext_clk = ~i_ext_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge i_clk);
   endtask

   // Window length is a whole number of periods, so phase does not matter
   task automatic measure(input int k);
      clr <= 1'b1;
      @(posedge i_clk);
      clr <= 1'b0;
      repeat (k) @(posedge i_clk);
      #1;
      hi = load_high;
      ed = load_edges;
   endtask

   task automatic set_cmp(input logic [7:0] lo, input logic [7:0] hb);
      wr(8'h11, lo);
      wr(8'h12, hb);
   endtask

   task automatic t_regs;
      logic [7:0] d;
      rd(8'h02, d); check({8'h00, d}, 16'h0000);
      rd(8'h10, d); check({8'h00, d}, 16'h0000);
      wr(8'h13, 8'h5A);
      rd(8'h13, d); check({8'h00, d}, 16'h0000);
      wr(8'h10, 8'h42);
      wr(8'h11, 8'h40);
      rd(8'h10, d); check({8'h00, d}, 16'h0002);
      wr(8'h12, 8'h40);
      rd(8'h10, d); check({8'h00, d}, 16'h0042);
      $display("test regs done");
   endtask

   task automatic t_edge;
      logic [7:0] d;
      wr(8'h03, 8'h00);
      wr(8'h02, 8'h01);
      idle(600);
      measure(256);
      check(hi, 16'd192);
      check(ed, 16'd2);
      wr(8'h04, 8'h01);
      idle(8);
      measure(256);
      check(hi, 16'd64);
      wr(8'h04, 8'h00);
      // Duty changed through the high byte only, picked up at overflow
      wr(8'h12, 8'hC0);
      idle(600);
      measure(256);
      check(hi, 16'd64);
      rd(8'h11, d); check({8'h00, d}, 16'h00C0);
      wr(8'h11, 8'h40);
      idle(600);
      measure(256);
      check(hi, 16'd0);
      $display("test edge done");
   endtask

   task automatic t_center;
      logic [7:0] cmp [3] = '{8'h40, 8'h00, 8'hFF};
      // Up edge at compare+1, down edge at ~compare: 2*(256-C)-2 high for C>0, C=0 always high
      logic [15:0] exp [3] = '{16'd382, 16'd512, 16'd0};
      wr(8'h05, 8'h01);
      for (int i = 0; i < 3; i++) begin
         set_cmp(cmp[i], cmp[i]);
         idle(1100);
         measure(512);
         check(hi, exp[i]);
         if (i == 0) check(ed, 16'd2);
      end
      wr(8'h05, 8'h00);
      $display("test center done");
   endtask

   task automatic t_freq;
      logic [7:0] sel [3] = '{8'h01, 8'h03, 8'h09};
      logic [15:0] exp [3] = '{16'd128, 16'd32, 16'd16};
      wr(8'h10, 8'h46);
      for (int i = 0; i < 3; i++) begin
         wr(8'h02, sel[i]);
         set_cmp(8'h00, 8'h04);
         // First low-byte match may take 256 slow counter clocks
         idle(2100);
         measure(512);
         check(hi, 16'd256);
         check(ed, exp[i]);
      end
      wr(8'h02, 8'h01);
      set_cmp(8'h00, 8'h00);
      idle(1100);
      measure(512);
      check(ed, 16'd2);
      $display("test freq done");
   endtask

   task automatic t_event;
      logic [7:0] d;
      wr(8'h02, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h00);
      wr(8'h10, 8'h4E);
      set_cmp(8'h10, 8'h00);
      wr(8'h02, 8'h01);
      for (int i = 0; i < 64 && o_chan_event_flag[0] !== 1'b1; i++)
         @(posedge i_clk);
      check({15'h0000, o_chan_event_flag[0]}, 16'h0001);
      rd(8'h06, d); check({8'h00, d}, 16'h0001);
      wr(8'h06, 8'h00);
      idle(4);
      check({10'h000, o_chan_event_flag}, 16'h0000);
      $display("test event done");
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      idle(10);
      i_reset <= 1'b0;
      t_regs();
      t_edge();
      t_center();
      t_freq();
      t_event();
      results();
   end

   // Tests take about 17000 cycles; a hang is cut off well beyond that
   initial begin
      repeat (60000) @(posedge i_clk);
      num_errors++;
      results();
   end
endmodule
